// ==== tcsg_pkg.sv ====
`default_nettype none
package tcsg_pkg;
    // ==========================================
    // Register indices (byte address = 4 * index)
    localparam logic [3:0] TCSG_IDX_TONE_A_FINE = 4'h0;
    localparam logic [3:0] TCSG_IDX_TONE_A_COARSE = 4'h1;
    localparam logic [3:0] TCSG_IDX_TONE_B_FINE = 4'h2;
    localparam logic [3:0] TCSG_IDX_TONE_B_COARSE = 4'h3;
    localparam logic [3:0] TCSG_IDX_TONE_C_FINE = 4'h4;
    localparam logic [3:0] TCSG_IDX_TONE_C_COARSE = 4'h5;
    localparam logic [3:0] TCSG_IDX_NOISE_PERIOD = 4'h6;
    localparam logic [3:0] TCSG_IDX_MIXER_DISABLE = 4'h7;
    localparam logic [3:0] TCSG_IDX_AMPLITUDE_A = 4'h8;
    localparam logic [3:0] TCSG_IDX_AMPLITUDE_B = 4'h9;
    localparam logic [3:0] TCSG_IDX_AMPLITUDE_C = 4'ha;
    localparam logic [3:0] TCSG_IDX_ENV_FINE = 4'hb;
    localparam logic [3:0] TCSG_IDX_ENV_COARSE = 4'hc;
    localparam logic [3:0] TCSG_IDX_ENV_STATUS = 4'hd;
    localparam logic [3:0] TCSG_IDX_ENV_SHAPE = 4'he;
    localparam int TCSG_NUM_REGS = 16;
    localparam logic [7:0] TCSG_REG_RESET = 8'h00;
    // ==========================================
    // Field positions
    localparam int TCSG_COARSE_BITS = 4;
    localparam int TCSG_NOISE_BITS = 5;
    localparam int TCSG_MIX_NOISE_LSB = 3;
    localparam int TCSG_AMP_ENV_BIT = 4;
    localparam int TCSG_SHAPE_HOLD = 0;
    localparam int TCSG_SHAPE_ALT = 1;
    localparam int TCSG_SHAPE_ATTACK = 2;
    localparam int TCSG_SHAPE_CONT = 3;
    // ==========================================
    // Timing: base rates in Hz, system clock in Hz
    localparam int TCSG_CLOCK_HZ = 200000000;
    localparam int TCSG_TONE_BASE_HZ = 223750;
    localparam int TCSG_ENV_BASE_HZ = 13984;
    // Tick at twice the base rate: f = base/period, two edges a period
    localparam int TCSG_TONE_TICK_CYC = TCSG_CLOCK_HZ / (2 * TCSG_TONE_BASE_HZ);
    // Envelope steps 16 per repetition
    localparam int TCSG_ENV_TICK_CYC = TCSG_CLOCK_HZ / (16 * TCSG_ENV_BASE_HZ);
    localparam logic [16:0] TCSG_LFSR_SEED = 17'h00001;
endpackage : tcsg_pkg
`default_nettype wire

// ==== tcsg_sound_gen.sv ====
`default_nettype none
module tcsg_sound_gen
    import tcsg_pkg::*;
#(
    parameter int TONE_TICK_CYC = TCSG_TONE_TICK_CYC,
    parameter int ENV_TICK_CYC = TCSG_ENV_TICK_CYC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [2:0] chanOn,
    output logic [3:0] levelA,
    output logic [3:0] levelB,
    output logic [3:0] levelC
);
    // ==========================================
    // Register file
    typedef enum {ENV_RUN, ENV_HOLD} tcsg_env_state_t;
    logic [7:0] regs_reg [TCSG_NUM_REGS];
    logic ackReg_reg;
    logic [31:0] rdata_reg;
    logic [3:0] regIdx;
    logic busReq;
    logic wrStrobe;
    logic shapeWrite;
    logic [2:0] toneOut_reg;
    logic noiseOut;
    logic [3:0] envLevel_reg;
    tcsg_env_state_t envState_reg;

    assign regIdx = wb_adr_i[5:2];
    assign busReq = wb_cyc_i && wb_stb_i && !ackReg_reg;
    // Writes land on the ack edge, while the master still holds its data
    assign wrStrobe = wb_cyc_i && wb_stb_i && ackReg_reg && wb_we_i && wb_sel_i[0];
    assign shapeWrite = wrStrobe && (regIdx == TCSG_IDX_ENV_SHAPE);
    assign wb_ack_o = ackReg_reg;
    assign wb_dat_o = rdata_reg;

    // One wait state: ack the cycle after the request
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ackReg_reg <= 1'b0;
        end else begin
            ackReg_reg <= busReq;
        end
    end

    // Address selects the register, data lands on ack edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            for (int i = 0; i < TCSG_NUM_REGS; i++) begin
                regs_reg[i] <= TCSG_REG_RESET;
            end
        end else if (wrStrobe) begin
            if (regIdx != TCSG_IDX_ENV_STATUS) begin
                regs_reg[regIdx] <= wb_dat_i[7:0];
            end
        end
    end

    // Index 13 reads live envelope level; others read stored bytes
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            rdata_reg <= 32'h00000000;
        end else if (busReq && !wb_we_i) begin
            if (regIdx == TCSG_IDX_ENV_STATUS) begin
                rdata_reg <= {28'h0000000, envLevel_reg};
            end else begin
                rdata_reg <= {24'h000000, regs_reg[regIdx]};
            end
        end
    end

    // ==========================================
    // Tone generators
    logic [11:0] tonePeriod [3];
    logic [11:0] toneCnt_reg [3];
    logic [15:0] preTone_reg;
    logic toneTick;

    assign toneTick = (preTone_reg == 16'(TONE_TICK_CYC - 1));

    always_ff @(posedge clock) begin
        if (sys_rst || toneTick) begin
            preTone_reg <= 16'h0000;
        end else begin
            preTone_reg <= preTone_reg + 16'h0001;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_tone
            // 256 * coarse nibble + fine byte
            assign tonePeriod[ch] = {regs_reg[2 * ch + 1][TCSG_COARSE_BITS - 1:0],
                regs_reg[2 * ch]};
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    toneCnt_reg[ch] <= 12'h000;
                    toneOut_reg[ch] <= 1'b0;
                end else if (toneTick) begin
                    // Period zero behaves as one, avoiding a stuck divider
                    if (toneCnt_reg[ch] + 12'h001 >= tonePeriod[ch]) begin
                        toneCnt_reg[ch] <= 12'h000;
                        toneOut_reg[ch] <= !toneOut_reg[ch];
                    end else begin
                        toneCnt_reg[ch] <= toneCnt_reg[ch] + 12'h001;
                    end
                end
            end
        end
    endgenerate

    // ==========================================
    // Noise generator
    logic [4:0] noisePeriod;
    logic [4:0] noiseCnt_reg;
    logic [16:0] lfsr_reg;

    assign noisePeriod = regs_reg[TCSG_IDX_NOISE_PERIOD][TCSG_NOISE_BITS - 1:0];
    assign noiseOut = lfsr_reg[0];

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            noiseCnt_reg <= 5'h00;
            lfsr_reg <= TCSG_LFSR_SEED;
        end else if (toneTick) begin
            if (noiseCnt_reg + 5'h01 >= noisePeriod) begin
                noiseCnt_reg <= 5'h00;
                lfsr_reg <= {lfsr_reg[0] ^ lfsr_reg[3], lfsr_reg[16:1]};
            end else begin
                noiseCnt_reg <= noiseCnt_reg + 5'h01;
            end
        end
    end

    // ==========================================
    // Envelope generator
    logic [15:0] envPeriod;
    logic [15:0] envCnt_reg;
    logic [15:0] preEnv_reg;
    logic envTick;
    logic envStep;
    logic envUp_reg;
    logic [3:0] envShape;
    logic cycleEnd;

    assign envPeriod = {regs_reg[TCSG_IDX_ENV_COARSE],
        regs_reg[TCSG_IDX_ENV_FINE]};
    assign envShape = regs_reg[TCSG_IDX_ENV_SHAPE][3:0];
    assign envTick = (preEnv_reg == 16'(ENV_TICK_CYC - 1));
    assign envStep = envTick && (envCnt_reg + 16'h0001 >= envPeriod);
    assign cycleEnd = envUp_reg ? (envLevel_reg == 4'hf) : (envLevel_reg == 4'h0);

    always_ff @(posedge clock) begin
        if (sys_rst || envTick) begin
            preEnv_reg <= 16'h0000;
        end else begin
            preEnv_reg <= preEnv_reg + 16'h0001;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || envStep) begin
            envCnt_reg <= 16'h0000;
        end else if (envTick) begin
            envCnt_reg <= envCnt_reg + 16'h0001;
        end
    end

    // A shape write restarts the envelope from its attack edge
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            envLevel_reg <= 4'hf;
            envUp_reg <= 1'b0;
            envState_reg <= ENV_RUN;
        end else if (shapeWrite) begin
            envUp_reg <= wb_dat_i[TCSG_SHAPE_ATTACK];
            envLevel_reg <= wb_dat_i[TCSG_SHAPE_ATTACK] ? 4'h0 : 4'hf;
            envState_reg <= ENV_RUN;
        end else if (envStep) begin
            case (envState_reg)
                ENV_RUN: begin
                    if (!cycleEnd) begin
                        envLevel_reg <= envUp_reg ? envLevel_reg + 4'h1
                            : envLevel_reg - 4'h1;
                    end else if (!envShape[TCSG_SHAPE_CONT]) begin
                        envLevel_reg <= 4'h0;
                        envState_reg <= ENV_HOLD;
                    end else if (envShape[TCSG_SHAPE_HOLD]) begin
                        // Hold keeps reached level, or flipped one if alternating
                        if (envShape[TCSG_SHAPE_ALT]) begin
                            envLevel_reg <= ~envLevel_reg;
                        end
                        envState_reg <= ENV_HOLD;
                    end else if (envShape[TCSG_SHAPE_ALT]) begin
                        envUp_reg <= !envUp_reg;
                    end else begin
                        envLevel_reg <= envUp_reg ? 4'h0 : 4'hf;
                    end
                end
                ENV_HOLD: begin
                    envLevel_reg <= envLevel_reg;
                end
                default: begin
                    envState_reg <= ENV_RUN;
                end
            endcase
        end
    end

    // ==========================================
    // Mixer and amplitude
    logic [3:0] chanLevel [3];
    generate
        for (ch = 0; ch < 3; ch++) begin : g_mix
            logic [7:0] ampReg;
            logic toneGate;
            logic noiseGate;
            assign ampReg = regs_reg[TCSG_IDX_AMPLITUDE_A + 4'(ch)];
            // Disabled source forces its term high, so it no longer gates
            assign toneGate = regs_reg[TCSG_IDX_MIXER_DISABLE][ch] || toneOut_reg[ch];
            assign noiseGate = regs_reg[TCSG_IDX_MIXER_DISABLE][TCSG_MIX_NOISE_LSB + ch]
                || noiseOut;
            assign chanLevel[ch] = ampReg[TCSG_AMP_ENV_BIT] ? envLevel_reg
                : ampReg[3:0];
            always_ff @(posedge clock) begin
                if (sys_rst) begin
                    chanOn[ch] <= 1'b0;
                end else begin
                    chanOn[ch] <= toneGate && noiseGate;
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            levelA <= 4'h0;
            levelB <= 4'h0;
            levelC <= 4'h0;
        end else begin
            levelA <= chanOn[0] ? chanLevel[0] : 4'h0;
            levelB <= chanOn[1] ? chanLevel[1] : 4'h0;
            levelC <= chanOn[2] ? chanLevel[2] : 4'h0;
        end
    end

    // ==========================================
    // Checks
    property p_ack_follows;
        @(posedge clock) disable iff (sys_rst)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    a_ack_follows: assert property (p_ack_follows) else $error("ack missing");

    property p_ack_single;
        @(posedge clock) disable iff (sys_rst)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_single: assert property (p_ack_single) else $error("ack held");

    property p_write_applies;
        @(posedge clock) disable iff (sys_rst)
        (wrStrobe && regIdx == TCSG_IDX_AMPLITUDE_A)
            |=> (regs_reg[TCSG_IDX_AMPLITUDE_A] == $past(wb_dat_i[7:0]));
    endproperty
    a_write_applies: assert property (p_write_applies) else $error("write lost");

    property p_fixed_level;
        @(posedge clock) disable iff (sys_rst)
        (chanOn[0] && !regs_reg[TCSG_IDX_AMPLITUDE_A][4])
            |=> (levelA == $past(regs_reg[TCSG_IDX_AMPLITUDE_A][3:0]));
    endproperty
    a_fixed_level: assert property (p_fixed_level) else $error("fixed vol");

    property p_env_level;
        @(posedge clock) disable iff (sys_rst)
        (chanOn[1] && regs_reg[TCSG_IDX_AMPLITUDE_B][4]) |=> (levelB == $past(envLevel_reg));
    endproperty
    a_env_level: assert property (p_env_level) else $error("env vol");

    property p_mix_off;
        @(posedge clock) disable iff (sys_rst)
        (!regs_reg[TCSG_IDX_MIXER_DISABLE][2] && !toneOut_reg[2])
            |=> !chanOn[2];
    endproperty
    a_mix_off: assert property (p_mix_off) else $error("mixer gate");

    property p_hold_still;
        @(posedge clock) disable iff (sys_rst)
        (envState_reg == ENV_HOLD && !shapeWrite) |=> $stable(envLevel_reg);
    endproperty
    a_hold_still: assert property (p_hold_still) else $error("hold moved");

    property p_nocont_zero;
        @(posedge clock) disable iff (sys_rst)
        (envStep && envState_reg == ENV_RUN && cycleEnd && !envShape[3] && !shapeWrite)
            |=> (envLevel_reg == 4'h0);
    endproperty
    a_nocont_zero: assert property (p_nocont_zero) else $error("no zero");

    property p_attack_up;
        @(posedge clock) disable iff (sys_rst)
        (envStep && envState_reg == ENV_RUN && !cycleEnd && envUp_reg && !shapeWrite)
            |=> (envLevel_reg == $past(envLevel_reg) + 4'h1);
    endproperty
    a_attack_up: assert property (p_attack_up) else $error("no count up");

    property p_ack_idle;
        @(posedge clock) disable iff (sys_rst)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack unasked");

    property p_tone_steady;
        @(posedge clock) disable iff (sys_rst)
        !toneTick |=> $stable(toneOut_reg);
    endproperty
    a_tone_steady: assert property (p_tone_steady) else $error("tone off tick");

    property p_noise_steady;
        @(posedge clock) disable iff (sys_rst)
        !toneTick |=> $stable(lfsr_reg);
    endproperty
    a_noise_steady: assert property (p_noise_steady) else $error("noise off tick");

    property p_env_steady;
        @(posedge clock) disable iff (sys_rst)
        (!envStep && !shapeWrite) |=> $stable(envLevel_reg);
    endproperty
    a_env_steady: assert property (p_env_steady) else $error("env off step");

    property p_alt_turn;
        @(posedge clock) disable iff (sys_rst)
        (envStep && envState_reg == ENV_RUN && cycleEnd && envShape == 4'ha && !shapeWrite)
            |=> (envUp_reg != $past(envUp_reg));
    endproperty
    a_alt_turn: assert property (p_alt_turn) else $error("no turn");

    property p_shape_restart;
        @(posedge clock) disable iff (sys_rst)
        (shapeWrite && wb_dat_i[TCSG_SHAPE_ATTACK])
            |=> (envLevel_reg == 4'h0 && envUp_reg);
    endproperty
    a_shape_restart: assert property (p_shape_restart) else $error("no attack start");

    property p_noise_gate;
        @(posedge clock) disable iff (sys_rst)
        (!regs_reg[TCSG_IDX_MIXER_DISABLE][TCSG_MIX_NOISE_LSB] && !noiseOut)
            |=> !chanOn[0];
    endproperty
    a_noise_gate: assert property (p_noise_gate) else $error("noise gate");
endmodule : tcsg_sound_gen
`default_nettype wire

// ==== tcsg_host_model.sv ====
`default_nettype none
// ==========================================
// Host side: classic Wishbone master
module tcsg_host_model (
    input wire logic clock,
    output logic wbCyc,
    output logic wbStb,
    output logic wbWe,
    output logic [5:0] wbAdr,
    output logic [3:0] wbSel,
    output logic [31:0] wbDatW,
    input wire logic wbAck,
    input wire logic [31:0] wbDatR
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = 6'h00;
        wbSel = 4'h0;
        wbDatW = 32'h00000000;
    end
    // Index selects the register, then data moves on the ack a cycle later
    task automatic access(input logic we, input logic [3:0] idx, input logic [7:0] d,
                          input logic [3:0] sel, output logic [31:0] q);
        @(posedge clock);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= {idx, 2'b00};
        wbSel <= sel;
        wbDatW <= {24'h000000, d};
        do @(posedge clock); while (wbAck !== 1'b1);
        q = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        // Released data toggles so a stale value never looks valid
        wbDatW <= ~{24'h000000, d};
    endtask : access
endmodule : tcsg_host_model
`default_nettype wire

// ==== tcsg_sound_gen_bench.sv ====
`default_nettype none
module tcsg_sound_gen_bench
    import tcsg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 2;
    logic clock = 1'b0;
    logic sysRst = 1'b1;
    logic wbCyc, wbStb, wbWe, wbAck;
    logic [5:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW, wbDatR, rdq;
    logic [2:0] chanOn;
    logic [3:0] levelA, levelB, levelC;
    int n_mismatch = 0;
    int checked = 0;
    int seed = 32'ha050;
    int shadow [16];
    always #2.5 clock = ~clock;
    tcsg_sound_gen #(.TONE_TICK_CYC(TICK), .ENV_TICK_CYC(TICK)) i_tcsg_sound_gen (
        .clock(clock), .sys_rst(sysRst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .chanOn(chanOn), .levelA(levelA),
        .levelB(levelB), .levelC(levelC));
    tcsg_host_model i_tcsg_host_model (
        .clock(clock), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatW(wbDatW), .wbAck(wbAck), .wbDatR(wbDatR));
    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input int idx, input logic [7:0] d, input logic [3:0] sel);
        i_tcsg_host_model.access(1'b1, idx[3:0], d, sel, rdq);
        if (sel[0] && idx != 13) shadow[idx] = d;
    endtask : wr
    task automatic rd(input int idx);
        i_tcsg_host_model.access(1'b0, idx[3:0], 8'h00, 4'h1, rdq);
    endtask : rd
    // Cycles between two changes of one channel output
    task automatic half_period(input int ch, output int n);
        logic last;
        int g;
        @(posedge clock);
        last = chanOn[ch];
        for (g = 0; g < 20000 && chanOn[ch] === last; g++) @(posedge clock);
        last = chanOn[ch];
        for (n = 0; n < 20000 && chanOn[ch] === last; n++) @(posedge clock);
    endtask : half_period
    task automatic report_and_stop();
        $display("mismatches %0d comparisons %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #400us;
        n_mismatch++;
        report_and_stop();
    end
    // ==========================================
    // Main sequence
    initial begin
        int n, changes;
        logic [7:0] v;
        logic [3:0] a;
        logic [11:0] per [3];
        logic [7:0] shp [6];
        logic [3:0] fin [6];
        per = '{12'h102, 12'h005, 12'h200};
        shp = '{8'h0, 8'h4, 8'h9, 8'hb, 8'hd, 8'hf};
        fin = '{4'h0, 4'h0, 4'h0, 4'hf, 4'hf, 4'h0};
        for (int i = 0; i < 16; i++) shadow[i] = 0;
        repeat (20) @(posedge clock);
        sysRst <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            if (i != 13) begin
                rd(i);
                check(rdq, 0);
            end
        end
        // Lane refusal against the shadow copy; the status index is written but never read back
        for (int i = 0; i < 15; i++) begin
            v = 8'($random(seed));
            wr(i, v, 4'h1);
            wr(i, ~v, 4'he);
        end
        for (int i = 0; i < 15; i++) begin
            if (i != 13) begin
                rd(i);
                check(rdq, shadow[i]);
            end
        end
        // Fixed volume with every source masked, unused mixer bits set
        wr(7, 8'hff, 4'h1);
        wr(8, 8'h0f, 4'h1);
        wr(9, 8'h07, 4'h1);
        wr(10, 8'h00, 4'h1);
        repeat (4) @(posedge clock);
        check(chanOn, 3'b111);
        check({levelA, levelB, levelC}, 12'hf70);
        // Tone period per channel, coarse upper nibble ignored
        for (int ch = 0; ch < 3; ch++) begin
            wr(7, 8'hff & ~(8'h01 << ch), 4'h1);
            wr(2 * ch, per[ch][7:0], 4'h1);
            wr(2 * ch + 1, {4'hf, per[ch][11:8]}, 4'h1);
            half_period(ch, n);
            check(n, per[ch] * TICK);
        end
        // Noise on channel A only
        wr(7, 8'hf7, 4'h1);
        wr(6, 8'he1, 4'h1);
        changes = 0;
        a = {1'b0, chanOn};
        repeat (3000) begin
            @(posedge clock);
            if (chanOn[0] !== a[0]) changes++;
            a = {1'b0, chanOn};
        end
        check(changes > 0, 1);
        check(chanOn[2:1], 2'b11);
        // Envelope shapes, end level after the run settles
        wr(7, 8'hff, 4'h1);
        wr(8, 8'h10, 4'h1);
        wr(9, 8'h10, 4'h1);
        wr(11, 8'h01, 4'h1);
        wr(12, 8'h00, 4'h1);
        for (int k = 0; k < 6; k++) begin
            wr(14, {4'ha, shp[k][3:0]}, 4'h1);
            repeat (400) @(posedge clock);
            check(levelA, fin[k]);
            rd(13);
            check(rdq, fin[k]);
        end
        // Continue without hold keeps stepping
        wr(14, 8'h08, 4'h1);
        repeat (400) @(posedge clock);
        a = levelA;
        repeat (3) @(posedge clock);
        check(levelA !== a, 1);
        // Saw never climbs one step; alternate climbs back after the floor
        for (int k = 0; k < 2; k++) begin
            wr(14, k ? 8'h0a : 8'h08, 4'h1);
            repeat (4) @(posedge clock);
            changes = 0;
            a = levelA;
            repeat (200) begin
                @(posedge clock);
                if (levelA == a + 4'h1) changes++;
                a = levelA;
            end
            check(changes > 0, k);
        end
        // Coarse byte slows the envelope step
        wr(12, 8'h01, 4'h1);
        wr(14, 8'h0d, 4'h1);
        repeat (100) @(posedge clock);
        check(levelA < 4'h2, 1);
        report_and_stop();
    end
endmodule : tcsg_sound_gen_bench
`default_nettype wire
